// ---- hdl/seep_consts.vh ----
// constants shared by the serial eeprom command logic
`ifndef SEEP_CONSTS_VH
`define SEEP_CONSTS_VH

// ==========================================================
// clock and timing
`define SEEP_MCLK_MHZ        10
`define SEEP_TPROG_NS        5000000

// ==========================================================
// op-code decode (bit 3 is don't care or the array half select)
`define SEEP_OPC_MASK        8'hF7
`define SEEP_OP_SET_PERMIT   8'h06
`define SEEP_OP_CLR_PERMIT   8'h04
`define SEEP_OP_STATUS       8'h05
`define SEEP_OP_ARR_READ     8'h03
`define SEEP_OP_ARR_WRITE    8'h02
`define SEEP_OP_ID_READ      8'h83
`define SEEP_OP_ID_WRITE     8'h82

// ==========================================================
// field positions
`define SEEP_HALF_BIT        3
`define SEEP_ID_SPACE_BIT    7
`define SEEP_SEAL_DATA_BIT   1
`define SEEP_BYTE_LAST       3'h7
`define SEEP_BIT_FIRST       3'h0

// ==========================================================
// values and encodings
`define SEEP_ERASED          8'hFF
`define SEEP_GUARD_ALL       2'h3
`define SEEP_GUARD_HALF      2'h2
`define SEEP_GUARD_QUARTER   2'h1
`define SEEP_SRC_ARRAY       2'h0
`define SEEP_SRC_ID          2'h1
`define SEEP_SRC_SEAL        2'h2
`define SEEP_SRC_STATUS      2'h3
`define SEEP_WK_ARRAY        2'h0
`define SEEP_WK_ID           2'h1
`define SEEP_WK_SEAL         2'h2
`define SEEP_ARM_NONE        2'h0
`define SEEP_ARM_SET         2'h1
`define SEEP_ARM_CLR         2'h2

`endif

// ---- hdl/seep_link_sync.v ----
// two-flop synchroniser for the link pins
`timescale 1ns/1ns
`default_nettype none

module seep_link_sync #(
    parameter WIDTH = 3
) (
    // clock and reset
    input  wire             mclk,
    input  wire             sys_rst,
    // pins and synchronised levels
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta;

    // ======================================================
    // first stage feeds only the second
    always @(posedge mclk) begin
        if (sys_rst) begin
            meta <= {WIDTH{1'b1}};
            dout <= {WIDTH{1'b1}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/seep_skid.v ----
// small fifo between the read pointer and the output shifter
`timescale 1ns/1ns
`default_nettype none

module seep_skid #(
    parameter WIDTH = 8,
    parameter DEPTH = 2,
    parameter AW    = 1
) (
    // clock and reset
    input  wire             mclk,
    input  wire             sys_rst,
    input  wire             flush,
    // filling side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wr_idx;
    reg [AW-1:0]    rd_idx;
    reg [AW:0]      fill;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data  = store[rd_idx];

    // ======================================================
    // pointers wrap at depth
    always @(posedge mclk) begin
        if (sys_rst || flush) begin
            wr_idx <= {AW{1'b0}};
            rd_idx <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                store[wr_idx] <= in_data;
                wr_idx        <= (wr_idx == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_idx + 1'b1;
            end
            if (pop)
                rd_idx <= (rd_idx == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_idx + 1'b1;
            if (push && !pop)
                fill <= fill + 1'b1;
            else if (pop && !push)
                fill <= fill - 1'b1;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/seep_core.v ----
// serial eeprom command logic: array, page write, id page and seal
//
// Functional notes
// - array read takes op-code and address byte, then streams bytes while selected
// - sequential array read wraps from the top address to zero
// - select rising at any bit aborts a read and releases the output
// - array write takes address and data; at most 16 bytes of one page
// - write address wraps within the page, upper bits unchanged
// - more than 16 data bytes keep only the last 16
// - array changes need the permit latch and never touch guarded blocks
// - permit latch clears when the array write cycle completes
// - 16-byte id page, first three bytes preset with identity codes
// - id program uses address with id-space bit clear, low four bits select byte
// - seal needs the permit latch set beforehand
// - seal uses id-space bit set and data byte bit one set
// - seal runs only on deselect at a byte boundary, starting timed cycle
// - seal refused with full guard, busy cycle, or already sealed
// - seal flag makes id page read-only and is cleared only by reset
// - id read outputs selected byte and increments while selected
// - id read wraps; past the last byte it continues from byte zero
// - id read ignored while a program cycle runs
// - seal query returns sealed flag in bit zero, repeated
// - seal query ignored while a program cycle runs
// - array reads all ones after reset
// - array op-codes carry the half select in op-code bit three
// - id op-codes shared with seal pair, split by id-space bit
// - input sampled on rising clock, output on falling, msb first
// - during a program cycle only the status query is accepted
`include "seep_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module seep_core #(
    parameter integer PROG_CYCLES  = (`SEEP_TPROG_NS / 1000) * `SEEP_MCLK_MHZ,
    parameter [7:0]   MAKER_CODE   = 8'h5A,  // arbitrary
    parameter [7:0]   FAMILY_CODE  = 8'hA5,  // arbitrary
    parameter [7:0]   DENSITY_CODE = 8'h3C,  // arbitrary
    parameter integer ADDR_W       = 9,
    parameter integer PAGE_W       = 4
) (
    // clock and reset
    input  wire mclk,
    input  wire sys_rst,
    // link pins
    input  wire cs_n,
    input  wire sck,
    input  wire si,
    output reg  so_out,
    output reg  so_oe,
    // configuration
    input  wire block_guard_high_bit,
    input  wire block_guard_low_bit,
    // status
    output reg  write_permit_latch,
    output reg  program_busy,
    output reg  id_page_sealed
);

    localparam integer ARR_N  = 1 << ADDR_W;
    localparam integer PAGE_N = 1 << PAGE_W;
    localparam integer CW     = $clog2(PROG_CYCLES + 1);
    localparam [CW-1:0] PROG_LAST = PROG_CYCLES[CW-1:0] - 1'b1;

    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_OPC   = 6'h02;
    localparam [5:0] ST_ADDR  = 6'h04;
    localparam [5:0] ST_RDATA = 6'h08;
    localparam [5:0] ST_WDATA = 6'h10;
    localparam [5:0] ST_SKIP  = 6'h20;

    // ======================================================
    // pin synchronisation and edges
    wire [2:0] pins_s;
    reg  [2:0] pins_prev;

    seep_link_sync #(
        .WIDTH (3)
    ) u_sync (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .din     ({cs_n, sck, si}),
        .dout    (pins_s)
    );

    wire cs_hi    = pins_s[2];
    wire cs_rise  = pins_s[2] & ~pins_prev[2];
    wire sck_rise = pins_s[1] & ~pins_prev[1];
    wire sck_fall = ~pins_s[1] & pins_prev[1];
    wire si_s     = pins_s[0];

    // ======================================================
    // state
    reg [5:0]        state;
    reg [2:0]        ibit;
    reg [6:0]        ishift;
    reg [2:0]        ocnt;
    reg [6:0]        oshift;
    reg              half_sel;
    reg              op_is_id;
    reg              op_is_write;
    reg [1:0]        src;
    reg [1:0]        wkind;
    reg [1:0]        arm;
    reg [ADDR_W-1:0] rd_ptr;
    reg [PAGE_W-1:0] id_ptr;
    reg [ADDR_W-1:0] wr_addr;
    reg              got_byte;
    reg              seal_data_ok;
    reg [1:0]        pend_kind;
    reg [CW-1:0]     prog_cnt;
    reg [7:0]        pbuf   [0:PAGE_N-1];
    reg [PAGE_N-1:0] pvalid;
    reg [7:0]        arr    [0:ARR_N-1];
    reg [7:0]        idpage [0:PAGE_N-1];

    wire [7:0] in_byte   = {ishift, si_s};
    wire       byte_done = sck_rise & (ibit == `SEEP_BYTE_LAST);
    wire [7:0] opc_key   = in_byte & `SEEP_OPC_MASK;
    wire [1:0] guard     = {block_guard_high_bit, block_guard_low_bit};
    wire       prog_done = program_busy & (prog_cnt == PROG_LAST);

    // guarded upper part of the array per guard setting
    function guarded;
        input [ADDR_W-1:0] a;
        input [1:0]        g;
        begin
            case (g)
                `SEEP_GUARD_ALL:     guarded = 1'b1;
                `SEEP_GUARD_HALF:    guarded = a[ADDR_W-1];
                `SEEP_GUARD_QUARTER: guarded = &a[ADDR_W-1:ADDR_W-2];
                default:             guarded = 1'b0;
            endcase
        end
    endfunction

    // ======================================================
    // read prefetch buffer
    reg  [7:0] push_data;
    wire       push_ready;
    wire       pop_valid;
    wire [7:0] pop_data;
    wire       push_valid = (state == ST_RDATA);
    wire       pop_ready  = (state == ST_RDATA) & sck_fall & (ocnt == `SEEP_BIT_FIRST);
    wire [7:0] status_byte = {4'h0, guard, write_permit_latch, program_busy};

    always @* begin
        case (src)
            `SEEP_SRC_ARRAY: push_data = arr[rd_ptr];
            `SEEP_SRC_ID:    push_data = idpage[id_ptr];
            `SEEP_SRC_SEAL:  push_data = {7'h00, id_page_sealed};
            default:         push_data = status_byte;
        endcase
    end

    // flushed on deselect so a new read never sees stale bytes
    seep_skid #(
        .WIDTH (8),
        .DEPTH (2),
        .AW    (1)
    ) u_skid (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .flush     (cs_hi),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    // ======================================================
    // command sequencer
    integer k;
    always @(posedge mclk) begin
        if (sys_rst) begin
            pins_prev          <= 3'h7;
            state              <= ST_IDLE;
            ibit               <= 3'h0;
            ishift             <= 7'h00;
            ocnt               <= 3'h0;
            oshift             <= 7'h00;
            so_out             <= 1'b0;
            so_oe              <= 1'b0;
            half_sel           <= 1'b0;
            op_is_id           <= 1'b0;
            op_is_write        <= 1'b0;
            src                <= `SEEP_SRC_ARRAY;
            wkind              <= `SEEP_WK_ARRAY;
            arm                <= `SEEP_ARM_NONE;
            rd_ptr             <= {ADDR_W{1'b0}};
            id_ptr             <= {PAGE_W{1'b0}};
            wr_addr            <= {ADDR_W{1'b0}};
            got_byte           <= 1'b0;
            seal_data_ok       <= 1'b0;
            pend_kind          <= `SEEP_WK_ARRAY;
            prog_cnt           <= {CW{1'b0}};
            pvalid             <= {PAGE_N{1'b0}};
            write_permit_latch <= 1'b0;
            program_busy       <= 1'b0;
            id_page_sealed     <= 1'b0;
        end else begin
            pins_prev <= pins_s;
            so_oe     <= (state == ST_RDATA) & ~cs_hi;

            // timed program cycle
            if (program_busy) begin
                prog_cnt <= prog_cnt + 1'b1;
                if (prog_done) begin
                    program_busy       <= 1'b0;
                    write_permit_latch <= 1'b0;
                    if (pend_kind == `SEEP_WK_SEAL)
                        id_page_sealed <= 1'b1;
                end
            end

            // deselect at a byte boundary commits the command
            if (cs_rise && ibit == `SEEP_BIT_FIRST) begin
                if (state == ST_SKIP) begin
                    if (arm == `SEEP_ARM_SET)
                        write_permit_latch <= 1'b1;
                    else if (arm == `SEEP_ARM_CLR)
                        write_permit_latch <= 1'b0;
                end
                if (state == ST_WDATA && got_byte && !program_busy && write_permit_latch) begin
                    if (wkind == `SEEP_WK_ARRAY ||
                        (wkind == `SEEP_WK_ID && !id_page_sealed) ||
                        (wkind == `SEEP_WK_SEAL && seal_data_ok && !id_page_sealed &&
                         guard != `SEEP_GUARD_ALL)) begin
                        program_busy <= 1'b1;
                        prog_cnt     <= {CW{1'b0}};
                        pend_kind    <= wkind;
                    end
                end
            end

            if (cs_hi) begin
                state    <= ST_IDLE;
                ibit     <= 3'h0;
                ocnt     <= 3'h0;
                got_byte <= 1'b0;
            end else begin
                if (sck_rise) begin
                    ishift <= in_byte[6:0];
                    ibit   <= ibit + 1'b1;
                end
                case (state)
                    ST_IDLE: begin
                        state  <= ST_OPC;
                        arm    <= `SEEP_ARM_NONE;
                        if (!program_busy)
                            pvalid <= {PAGE_N{1'b0}};
                    end
                    ST_OPC: begin
                        if (byte_done) begin
                            half_sel <= in_byte[`SEEP_HALF_BIT];
                            state    <= ST_SKIP;
                            if (opc_key == `SEEP_OP_STATUS) begin
                                src   <= `SEEP_SRC_STATUS;
                                state <= ST_RDATA;
                            end else if (!program_busy) begin
                                case (opc_key)
                                    `SEEP_OP_SET_PERMIT: arm <= `SEEP_ARM_SET;
                                    `SEEP_OP_CLR_PERMIT: arm <= `SEEP_ARM_CLR;
                                    `SEEP_OP_ARR_READ, `SEEP_OP_ARR_WRITE,
                                    `SEEP_OP_ID_READ, `SEEP_OP_ID_WRITE: begin
                                        state       <= ST_ADDR;
                                        op_is_id    <= in_byte[`SEEP_ID_SPACE_BIT];
                                        op_is_write <= ~in_byte[0];
                                    end
                                    default: arm <= `SEEP_ARM_NONE;
                                endcase
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (byte_done) begin
                            rd_ptr  <= {half_sel, in_byte};
                            wr_addr <= {half_sel, in_byte};
                            id_ptr  <= in_byte[PAGE_W-1:0];
                            if (op_is_write) begin
                                state <= ST_WDATA;
                                if (!op_is_id)
                                    wkind <= `SEEP_WK_ARRAY;
                                else if (in_byte[`SEEP_ID_SPACE_BIT])
                                    wkind <= `SEEP_WK_SEAL;
                                else
                                    wkind <= `SEEP_WK_ID;
                            end else begin
                                state <= ST_RDATA;
                                if (!op_is_id)
                                    src <= `SEEP_SRC_ARRAY;
                                else if (in_byte[`SEEP_ID_SPACE_BIT])
                                    src <= `SEEP_SRC_SEAL;
                                else
                                    src <= `SEEP_SRC_ID;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (byte_done && !program_busy) begin
                            got_byte     <= 1'b1;
                            seal_data_ok <= in_byte[`SEEP_SEAL_DATA_BIT];
                            pbuf[wr_addr[PAGE_W-1:0]]   <= in_byte;
                            pvalid[wr_addr[PAGE_W-1:0]] <= 1'b1;
                            wr_addr[PAGE_W-1:0]         <= wr_addr[PAGE_W-1:0] + 1'b1;
                        end
                    end
                    ST_RDATA: begin
                        if (push_valid && push_ready) begin
                            rd_ptr <= rd_ptr + 1'b1;
                            id_ptr <= id_ptr + 1'b1;
                        end
                        if (sck_fall) begin
                            ocnt <= ocnt + 1'b1;
                            if (ocnt == `SEEP_BIT_FIRST) begin
                                so_out <= pop_valid ? pop_data[7] : 1'b1;
                                oshift <= pop_valid ? pop_data[6:0] : 7'h7F;
                            end else begin
                                so_out <= oshift[6];
                                oshift <= {oshift[5:0], 1'b0};
                            end
                        end
                    end
                    ST_SKIP: begin
                        if (byte_done)
                            arm <= `SEEP_ARM_NONE;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // ======================================================
    // array storage, erased at reset; page buffer lands at cycle end
    always @(posedge mclk) begin
        if (sys_rst) begin
            for (k = 0; k < ARR_N; k = k + 1)
                arr[k] <= `SEEP_ERASED;
        end else if (prog_done && pend_kind == `SEEP_WK_ARRAY) begin
            for (k = 0; k < PAGE_N; k = k + 1)
                if (pvalid[k] && !guarded({wr_addr[ADDR_W-1:PAGE_W], k[PAGE_W-1:0]}, guard))
                    arr[{wr_addr[ADDR_W-1:PAGE_W], k[PAGE_W-1:0]}] <= pbuf[k];
        end
    end

    // ======================================================
    // id page, identity codes preset, application bytes erased
    integer j;
    always @(posedge mclk) begin
        if (sys_rst) begin
            for (j = 0; j < PAGE_N; j = j + 1)
                idpage[j] <= `SEEP_ERASED;
            idpage[0] <= MAKER_CODE;
            idpage[1] <= FAMILY_CODE;
            idpage[2] <= DENSITY_CODE;
        end else if (prog_done && pend_kind == `SEEP_WK_ID) begin
            for (j = 0; j < PAGE_N; j = j + 1)
                if (pvalid[j])
                    idpage[j] <= pbuf[j];
        end
    end

endmodule

`default_nettype wire

// ---- test/seep_core_assertions.sv ----
// checker for the serial eeprom command logic
`timescale 1ns/1ns
`default_nettype none

module seep_core_chk #(
    parameter integer PROG_CYCLES = 20
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // link pins
    input wire logic cs_n,
    input wire logic so_oe,
    // configuration and status
    input wire logic block_guard_high_bit,
    input wire logic block_guard_low_bit,
    input wire logic write_permit_latch,
    input wire logic program_busy,
    input wire logic id_page_sealed
);
    // ==========================================================
    // busy length counter
    logic [31:0] busy_cnt;
    always_ff @(posedge mclk) begin
        if (sys_rst || !program_busy) busy_cnt <= 32'h0;
        else busy_cnt <= busy_cnt + 32'h1;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // properties
    sequence s_desel;
        $rose(cs_n);
    endsequence
    sequence s_cycle_end;
        $fell(program_busy);
    endsequence
    property p_oe_release;
        s_desel |-> ##[1:6] !so_oe;
    endproperty
    property p_oe_idle;
        cs_n [*6] |-> !so_oe;
    endproperty
    property p_seal_sticky;
        id_page_sealed |=> id_page_sealed;
    endproperty
    property p_permit_end;
        s_cycle_end |-> !write_permit_latch;
    endproperty
    property p_busy_len;
        s_cycle_end |-> busy_cnt == PROG_CYCLES;
    endproperty
    property p_start_permit;
        $rose(program_busy) |-> $past(write_permit_latch);
    endproperty
    property p_start_desel;
        $rose(program_busy) |-> cs_n;
    endproperty
    property p_permit_hold;
        program_busy && $past(program_busy) |-> $stable(write_permit_latch);
    endproperty
    property p_seal_cause;
        $rose(id_page_sealed) |-> $past(program_busy) && !(block_guard_high_bit && block_guard_low_bit);
    endproperty

    a_oe_release: assert property (p_oe_release) else $error("output held after deselect");
    a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
    a_seal_sticky: assert property (p_seal_sticky) else $error("seal flag cleared");
    a_permit_end: assert property (p_permit_end) else $error("permit set after cycle");
    a_busy_len: assert property (p_busy_len) else $error("program cycle length wrong");
    a_start_permit: assert property (p_start_permit) else $error("cycle without permit");
    a_start_desel: assert property (p_start_desel) else $error("cycle started while selected");
    a_permit_hold: assert property (p_permit_hold) else $error("permit changed during cycle");
    a_seal_cause: assert property (p_seal_cause) else $error("seal set without valid cycle");
endmodule

bind seep_core seep_core_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .mclk, .sys_rst, .cs_n, .so_oe, .block_guard_high_bit,
    .block_guard_low_bit, .write_permit_latch, .program_busy, .id_page_sealed);
`default_nettype wire

// ---- test/seep_host.sv ----
// host side link master model for the serial eeprom bench
`timescale 1ns/1ns
`default_nettype none

module seep_host (
    // clock
    input  wire logic mclk,
    // link pins
    output var  logic cs_n,
    output var  logic sck,
    output var  logic si,
    input  wire logic so_out,
    input  wire logic so_oe
);
    initial {cs_n, sck, si} = 3'h4;

    task automatic start();
        cs_n = 1'b0;
        repeat (2) @(negedge mclk);
    endtask

    // 8 mclk per bit; read late in the high phase
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        for (int i = 0; i < nb; i++) begin
            si = tx[7-i];
            repeat (4) @(negedge mclk);
            sck = 1'b1;
            repeat (4) @(negedge mclk);
            rx = {rx[6:0], so_oe ? so_out : 1'bx};
            sck = 1'b0;
        end
    endtask

    task automatic stop();
        cs_n = 1'b1;
        repeat (8) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ---- test/seep_core_test.sv ----
// self-checking bench for the serial eeprom command logic
`timescale 1ns/1ns
`default_nettype none

module seep_core_test;
    localparam integer     PROG    = 800;
    localparam logic [7:0] MAKER   = 8'h3A; // arbitrary
    localparam logic [7:0] FAMILY  = 8'hC5; // arbitrary
    localparam logic [7:0] DENSITY = 8'h6E; // arbitrary
    logic       mclk     = 1'b0;
    logic       sys_rst  = 1'b1;
    logic       guard_hi = 1'b0;
    logic       guard_lo = 1'b0;
    logic       cs_n, sck, si, so_out, so_oe, permit_latch, busy, sealed;
    logic [7:0] rx;
    logic [7:0] q[$];
    int         fails       = 0;
    int         check_count = 0;

    always #50 mclk = ~mclk;

    seep_core #(.PROG_CYCLES(PROG), .MAKER_CODE(MAKER), .FAMILY_CODE(FAMILY), .DENSITY_CODE(DENSITY)) u_dut (
        .mclk, .sys_rst, .cs_n, .sck, .si, .so_out, .so_oe,
        .block_guard_high_bit(guard_hi), .block_guard_low_bit(guard_lo),
        .write_permit_latch(permit_latch), .program_busy(busy), .id_page_sealed(sealed));
    seep_host u_host (.mclk, .cs_n, .sck, .si, .so_out, .so_oe);

    // ==========================================================
    // access tasks
    task automatic chk(input logic [7:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic head(input logic [7:0] op, ad);
        u_host.start();
        u_host.xfer(op, 8, rx);
        u_host.xfer(ad, 8, rx);
    endtask
    task automatic op_only(input logic [7:0] op);
        u_host.start();
        u_host.xfer(op, 8, rx);
        u_host.stop();
    endtask
    task automatic send(input logic [7:0] op, ad, d[$]);
        head(op, ad);
        foreach (d[i]) u_host.xfer(d[i], 8, rx);
        u_host.stop();
    endtask
    task automatic rd(input logic [7:0] op, ad, e[$], input string what);
        head(op, ad);
        foreach (e[i]) begin
            u_host.xfer(8'h00, 8, rx);
            chk(rx, e[i], what);
        end
        u_host.stop();
    endtask
    task automatic probe(input logic [7:0] op, ad, input int nb, input logic act, input string what);
        head(op, ad);
        u_host.xfer(8'h00, nb, rx);
        chk({7'h0, so_oe}, {7'h0, act}, what);
        u_host.stop();
        chk({7'h0, so_oe}, 8'h00, what);
    endtask
    task automatic wait_idle();
        repeat (2000) if (busy !== 1'b0) @(negedge mclk);
        chk({7'h0, busy}, 8'h00, "cycle end");
    endtask
    task automatic seal(input logic pm, input logic [7:0] d, input int nb, input logic acc);
        if (pm) op_only(8'h06);
        head(8'h82, 8'h80);
        u_host.xfer(d, nb, rx);
        u_host.stop();
        chk({7'h0, busy}, {7'h0, acc}, "seal start");
        wait_idle();
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // tests
    initial begin
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (8) @(negedge mclk);
        rd(8'h03, 8'h00, '{8'hFF, 8'hFF}, "erased");
        op_only(8'h06);
        for (int i = 0; i < 18; i++) q.push_back(8'(i));
        send(8'h02, 8'h0E, q);
        wait_idle();
        chk({7'h0, permit_latch}, 8'h00, "permit after write");
        rd(8'h03, 8'h0E, '{8'h10, 8'h11, 8'hFF}, "page wrap");
        rd(8'h03, 8'h00, '{8'h02, 8'h03}, "last 16 kept");
        op_only(8'h06);
        op_only(8'h04);
        send(8'h02, 8'h20, '{8'h55});
        chk({7'h0, busy}, 8'h00, "write no permit");
        rd(8'h03, 8'h20, '{8'hFF}, "no permit no change");
        $display("test array write done");
        guard_lo = 1'b1;
        op_only(8'h06);
        send(8'h0A, 8'hFF, '{8'hA5});
        wait_idle();
        guard_lo = 1'b0;
        rd(8'h0B, 8'hFF, '{8'hFF}, "guarded top");
        op_only(8'h06);
        send(8'h0A, 8'hFF, '{8'h5A});
        wait_idle();
        rd(8'h0B, 8'hFF, '{8'h5A, 8'h02}, "array wrap");
        probe(8'h03, 8'h00, 3, 1'b1, "abort mid byte");
        rd(8'h03, 8'h01, '{8'h03}, "read after abort");
        $display("test guard and read done");
        rd(8'h83, 8'h00, '{MAKER, FAMILY, DENSITY, 8'hFF}, "id codes");
        op_only(8'h06);
        send(8'h82, 8'h43, '{8'h77, 8'h78});
        wait_idle();
        rd(8'h83, 8'h03, '{8'h77, 8'h78}, "id program");
        op_only(8'h06);
        send(8'h02, 8'h30, '{8'h99});
        probe(8'h83, 8'h00, 8, 1'b0, "id read while busy");
        probe(8'h83, 8'h80, 8, 1'b0, "seal query while busy");
        rd(8'h05, 8'h00, '{8'h03}, "status while busy");
        wait_idle();
        rd(8'h03, 8'h30, '{8'h99}, "write during busy");
        $display("test busy done");
        rd(8'h83, 8'h80, '{8'h00, 8'h00}, "seal query open");
        seal(1'b0, 8'h02, 8, 1'b0);
        seal(1'b1, 8'hFD, 8, 1'b0);
        {guard_hi, guard_lo} = 2'h3;
        seal(1'b1, 8'h02, 8, 1'b0);
        {guard_hi, guard_lo} = 2'h0;
        seal(1'b1, 8'h02, 7, 1'b0);
        seal(1'b1, 8'h02, 8, 1'b1);
        chk({7'h0, sealed}, 8'h01, "sealed");
        rd(8'h83, 8'h80, '{8'h01, 8'h01}, "seal query closed");
        seal(1'b1, 8'h02, 8, 1'b0);
        op_only(8'h06);
        send(8'h82, 8'h03, '{8'h11});
        wait_idle();
        rd(8'h83, 8'h03, '{8'h77}, "sealed page");
        $display("test seal done");
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
